// file: tce_pkg.sv
// Constants for the transparent channel event and error block.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses.
package tce_pkg;

  // Register byte addresses
  localparam logic [7:0] TCE_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] TCE_ACT_ADDR     = 8'h04;
  localparam logic [7:0] TCE_STATUS_ADDR  = 8'h08;
  localparam logic [7:0] TCE_MASK_ADDR    = 8'h0C;
  localparam logic [7:0] TCE_SUSP_ADDR    = 8'h10;

  // Control register fields
  localparam int TCE_CTRL_MODE_LSB = 0;
  localparam int TCE_CTRL_ABT_BIT  = 3;
  localparam int TCE_CTRL_OOFM_BIT = 4;
  localparam logic [4:0] TCE_CTRL_RST = 5'h00;

  // Activate register: transmit channels at bit 0 upward, receive at bit 8 upward
  localparam int TCE_ACT_RX_LSB = 8;

  // Port modes; only the first four run the frame flywheel check
  localparam logic [2:0] TCE_MODE_T1   = 3'h0;
  localparam logic [2:0] TCE_MODE_E1   = 3'h1;
  localparam logic [2:0] TCE_MODE_2E1  = 3'h2;
  localparam logic [2:0] TCE_MODE_4E1  = 3'h3;

  // Frame lengths in bit clocks
  localparam logic [10:0] TCE_LEN_T1  = 11'h0C1;
  localparam logic [10:0] TCE_LEN_E1  = 11'h100;
  localparam logic [10:0] TCE_LEN_2E1 = 11'h200;
  localparam logic [10:0] TCE_LEN_4E1 = 11'h400;

  // Event and error bits of status and mask registers
  localparam int TCE_EV_EOB_TX  = 0;
  localparam int TCE_EV_EOB_RX  = 1;
  localparam int TCE_EV_FRAME_RECOVERY_EVENT    = 2;
  localparam int TCE_EV_ONR_TX  = 3;
  localparam int TCE_EV_FIFO_RUN_ERROR_TX = 4;
  localparam int TCE_EV_ONR_RX  = 5;
  localparam int TCE_EV_FIFO_RUN_ERROR_RX = 6;
  localparam int TCE_EV_FRAME_ALIGNMENT_CHANGE_ERROR    = 7;
  localparam int TCE_EV_OOF     = 8;
  localparam int TCE_EV_W       = 9;
  localparam logic [8:0] TCE_STATUS_RST = 9'h000;
  localparam logic [8:0] TCE_MASK_RST   = 9'h000;

  // Channel direction state, Gray along off -> run -> suspended
  typedef enum logic [1:0] {
    TCE_CH_OFF  = 2'b00,
    TCE_CH_RUN  = 2'b01,
    TCE_CH_SUSP = 2'b11
  } tce_ch_e;

endpackage : tce_pkg

// file: tce_chan.sv
// One channel: transmit and receive state with event detection.
// Assumes all inputs are on ref_clk_i; group frame pulses come pre-synchronised.
`timescale 1ns/1ps
module tce_chan
  import tce_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                act_tx_i,
  input  wire logic                act_rx_i,
  input  wire logic                tx_buf_done_i,
  input  wire logic                tx_eob_en_i,
  input  wire logic                tx_data_need_i,
  input  wire logic                tx_next_host_i,
  input  wire logic                tx_fifo_empty_i,
  input  wire logic                tx_dev_owns_i,
  input  wire logic                rx_buf_done_i,
  input  wire logic                rx_eob_en_i,
  input  wire logic                rx_fifo_ovf_i,
  input  wire logic                rx_dev_buf_i,
  input  wire logic                rx_fifo_orun_i,
  input  wire logic                frame_alignment_change_error_i,
  input  wire logic                oof_enter_i,
  input  wire logic                oof_exit_i,
  input  wire logic                oof_level_i,
  input  wire logic                oof_abort_i,
  input  wire logic                frame_recovery_event_mask_i,
  output logic [TCE_EV_W-1:0]      evt_o,
  output logic                     tx_run_o,
  output logic                     tx_susp_o,
  output logic                     rx_run_o,
  output logic                     rx_susp_o,
  output logic                     rx_ones_o
);

  tce_ch_e               tx_q, tx_d, rx_q, rx_d;
  logic [TCE_EV_W-1:0]   evt_d;
  logic                  rx_ones_d;

  always_comb begin
    tx_d  = tx_q;
    rx_d  = rx_q;
    evt_d = '0;
    // Transmit direction is independent of receive [R17]
    case (tx_q)
      TCE_CH_RUN: begin
        if (tx_data_need_i && tx_next_host_i) begin
          evt_d[TCE_EV_ONR_TX] = 1'b1;                        // [R05]
          tx_d = TCE_CH_OFF;                                  // [R16]
        end else if (tx_data_need_i && tx_fifo_empty_i && tx_dev_owns_i) begin
          evt_d[TCE_EV_FIFO_RUN_ERROR_TX] = 1'b1;                       // [R06]
          tx_d = TCE_CH_SUSP;
        end
        // Buffer end posts the event; descriptor advance is the DMA's own [R01]
        if (tx_buf_done_i && tx_eob_en_i) evt_d[TCE_EV_EOB_TX] = 1'b1;
      end
      TCE_CH_OFF, TCE_CH_SUSP: begin
        if (act_tx_i) tx_d = TCE_CH_RUN;                      // [R07]
      end
      default: tx_d = TCE_CH_OFF;
    endcase
    case (rx_q)
      TCE_CH_RUN: begin
        if (rx_buf_done_i && rx_eob_en_i) evt_d[TCE_EV_EOB_RX] = 1'b1; // [R03]
        if (oof_exit_i && !frame_recovery_event_mask_i) evt_d[TCE_EV_FRAME_RECOVERY_EVENT] = 1'b1;     // [R04]
        if (rx_fifo_ovf_i && !rx_dev_buf_i) begin
          evt_d[TCE_EV_ONR_RX] = 1'b1;                        // [R08]
          rx_d = TCE_CH_OFF;
        end else if (rx_fifo_orun_i) begin
          evt_d[TCE_EV_FIFO_RUN_ERROR_RX] = 1'b1;                       // [R09]
          rx_d = TCE_CH_SUSP;
        end
        if (frame_alignment_change_error_i) begin
          evt_d[TCE_EV_FRAME_ALIGNMENT_CHANGE_ERROR] = 1'b1;                          // [R11]
          if (oof_abort_i) rx_d = TCE_CH_SUSP;                // [R12]
        end
        if (oof_enter_i) begin
          evt_d[TCE_EV_OOF] = 1'b1;                           // [R13]
          if (oof_abort_i) rx_d = TCE_CH_SUSP;                // [R14]
        end
      end
      TCE_CH_OFF, TCE_CH_SUSP: begin
        if (act_rx_i) rx_d = TCE_CH_RUN;                      // [R10]
      end
      default: rx_d = TCE_CH_OFF;
    endcase
    // All-ones substitution while out of frame without abort [R13]
    rx_ones_d = (rx_d == TCE_CH_RUN) && oof_level_i && !oof_abort_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_q      <= TCE_CH_OFF;
      rx_q      <= TCE_CH_OFF;
      evt_o     <= '0;
      tx_run_o  <= 1'b0;
      tx_susp_o <= 1'b0;
      rx_run_o  <= 1'b0;
      rx_susp_o <= 1'b0;
      rx_ones_o <= 1'b0;
    end else begin
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      evt_o     <= evt_d;
      tx_run_o  <= (tx_d == TCE_CH_RUN);
      tx_susp_o <= (tx_d != TCE_CH_RUN);
      rx_run_o  <= (rx_d == TCE_CH_RUN);
      rx_susp_o <= (rx_d != TCE_CH_RUN);
      rx_ones_o <= rx_ones_d;
    end
  end

endmodule : tce_chan

// file: tce_top.sv
// Transparent-mode event and error handling for a channel group.
// Assumes datapath strobes on ref_clk_i and framer pins from another domain.
`timescale 1ns/1ps
// Overview of operation
// (R01) Transmit buffer end posts event, direction one
// (R02) Never report end-of-message in transparent mode
// (R03) Receive buffer end posts event, direction zero
// (R04) Out-of-frame to in-frame posts recovery unless masked; code posts it only for running receive channels
// (R05) Host-owned transmit buffer: ownership error, suspend; code deactivates the channel instead
// (R06) Transmit FIFO empty while owning buffer: run error
// (R07) Host supplies descriptors then reactivates transmit
// (R08) Receive overflow without buffer: ownership error, deactivate
// (R09) Receive FIFO overrun: run error, discard, suspend
// (R10) Host reactivates suspended receive channel
// (R11) Unexpected sync rise on T1/E1 ports: alignment error
// (R12) Alignment change: continue or suspend per abort
// (R13) Out-of-frame: error, discard, all-ones when not aborting
// (R14) Abort set: suspend, host reactivates after recovery
// (R15) Host keeps end-of-message flag zero
// (R16) Transmit ownership underflow deactivates, sends idle
// (R17) Channels and directions tracked independently
module tce_top
  import tce_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   irq_o,
  // Framer pins
  input  wire logic              link_clk_i,
  input  wire logic              receive_frame_sync_i,
  input  wire logic              out_of_frame_i,
  // Datapath strobes, one bit per channel
  input  wire logic [NUM_CH-1:0] tx_buf_done_i,
  input  wire logic [NUM_CH-1:0] tx_eob_en_i,
  input  wire logic [NUM_CH-1:0] tx_data_need_i,
  input  wire logic [NUM_CH-1:0] tx_next_host_i,
  input  wire logic [NUM_CH-1:0] tx_fifo_empty_i,
  input  wire logic [NUM_CH-1:0] tx_dev_owns_i,
  input  wire logic [NUM_CH-1:0] rx_buf_done_i,
  input  wire logic [NUM_CH-1:0] rx_eob_en_i,
  input  wire logic [NUM_CH-1:0] rx_fifo_ovf_i,
  input  wire logic [NUM_CH-1:0] rx_dev_buf_i,
  input  wire logic [NUM_CH-1:0] rx_fifo_orun_i,
  // Per-channel controls to the datapath
  output logic [NUM_CH-1:0]      tx_idle_code_o,
  output logic [NUM_CH-1:0]      tx_bus_stop_o,
  output logic [NUM_CH-1:0]      rx_discard_o,
  output logic [NUM_CH-1:0]      rx_all_ones_o
);

  // Synchronisers for framer pins
  logic [2:0] clk_s_q;
  logic [2:0] sync_s_q;
  logic [2:0] oof_s_q;
  logic       sync_prev_q;
  logic       sync_prev_d;
  logic       oof_prev_q;
  logic       clk_rise;
  logic       sync_rise;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      clk_s_q  <= 3'h0;
      sync_s_q <= 3'h0;
      oof_s_q  <= 3'h0;
    end else begin
      clk_s_q  <= {clk_s_q[1:0], link_clk_i};
      sync_s_q <= {sync_s_q[1:0], receive_frame_sync_i};
      oof_s_q  <= {oof_s_q[1:0], out_of_frame_i};
    end
  end

  // Edge detection reads only stages two and three
  assign clk_rise  = clk_s_q[1] && !clk_s_q[2];
  assign sync_rise = clk_rise && sync_s_q[1] && !sync_prev_q;

  // Frame flywheel: counts link bit clocks between syncs
  logic [10:0] fly_cnt_q;
  logic [10:0] fly_cnt_d;
  logic        aligned_q;
  logic        aligned_d;
  logic [10:0] frame_len;
  logic        frame_alignment_change_error_q;
  logic        frame_alignment_change_error_d;
  logic        oof_enter_q;
  logic        oof_enter_d;
  logic        oof_exit_q;
  logic        oof_exit_d;
  logic [4:0]  ctrl_q;
  logic [4:0]  ctrl_d;
  logic [2:0]  port_mode;
  logic        flywheel_mode;

  assign port_mode     = ctrl_q[TCE_CTRL_MODE_LSB +: 3];
  // Only framed port modes check the sync position [R11]
  assign flywheel_mode = (port_mode == TCE_MODE_T1)  ||
                         (port_mode == TCE_MODE_E1)  ||
                         (port_mode == TCE_MODE_2E1) ||
                         (port_mode == TCE_MODE_4E1);

  always_comb begin
    case (port_mode)
      TCE_MODE_T1:  frame_len = TCE_LEN_T1;
      TCE_MODE_E1:  frame_len = TCE_LEN_E1;
      TCE_MODE_2E1: frame_len = TCE_LEN_2E1;
      TCE_MODE_4E1: frame_len = TCE_LEN_4E1;
      default:      frame_len = TCE_LEN_E1;
    endcase
    fly_cnt_d   = fly_cnt_q;
    aligned_d   = aligned_q;
    sync_prev_d = sync_prev_q;
    frame_alignment_change_error_d      = 1'b0;
    if (clk_rise) begin
      sync_prev_d = sync_s_q[1];
      if (sync_rise) begin
        // A sync rise away from the expected bit is an alignment change [R11]
        frame_alignment_change_error_d    = aligned_q && flywheel_mode && (fly_cnt_q != frame_len - 11'h001);
        fly_cnt_d = 11'h000;
        aligned_d = 1'b1;
      end else if (fly_cnt_q == frame_len - 11'h001) begin
        fly_cnt_d = 11'h000;
      end else begin
        fly_cnt_d = fly_cnt_q + 11'h001;
      end
    end
    // Loss of frame drops the flywheel lock
    if (oof_s_q[1]) aligned_d = 1'b0;
    oof_enter_d = oof_s_q[1] && !oof_prev_q;
    oof_exit_d  = !oof_s_q[1] && oof_prev_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fly_cnt_q   <= 11'h000;
      aligned_q   <= 1'b0;
      sync_prev_q <= 1'b0;
      frame_alignment_change_error_q      <= 1'b0;
      oof_prev_q  <= 1'b0;
      oof_enter_q <= 1'b0;
      oof_exit_q  <= 1'b0;
    end else begin
      fly_cnt_q   <= fly_cnt_d;
      aligned_q   <= aligned_d;
      sync_prev_q <= sync_prev_d;
      frame_alignment_change_error_q      <= frame_alignment_change_error_d;
      oof_prev_q  <= oof_s_q[1];
      oof_enter_q <= oof_enter_d;
      oof_exit_q  <= oof_exit_d;
    end
  end

  // Per-channel state
  logic [NUM_CH-1:0]   act_tx;
  logic [NUM_CH-1:0]   act_rx;
  logic [NUM_CH-1:0]   tx_run;
  logic [NUM_CH-1:0]   tx_susp;
  logic [NUM_CH-1:0]   rx_run;
  logic [NUM_CH-1:0]   rx_susp;
  logic [NUM_CH-1:0]   rx_ones;
  logic [TCE_EV_W-1:0] ch_evt [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tce_chan u_chan (
        .ref_clk_i       (ref_clk_i),
        .rst_n_i         (rst_n_i),
        .act_tx_i        (act_tx[g]),
        .act_rx_i        (act_rx[g]),
        .tx_buf_done_i   (tx_buf_done_i[g]),
        .tx_eob_en_i     (tx_eob_en_i[g]),
        .tx_data_need_i  (tx_data_need_i[g]),
        .tx_next_host_i  (tx_next_host_i[g]),
        .tx_fifo_empty_i (tx_fifo_empty_i[g]),
        .tx_dev_owns_i   (tx_dev_owns_i[g]),
        .rx_buf_done_i   (rx_buf_done_i[g]),
        .rx_eob_en_i     (rx_eob_en_i[g]),
        .rx_fifo_ovf_i   (rx_fifo_ovf_i[g]),
        .rx_dev_buf_i    (rx_dev_buf_i[g]),
        .rx_fifo_orun_i  (rx_fifo_orun_i[g]),
        .frame_alignment_change_error_i          (frame_alignment_change_error_q),
        .oof_enter_i     (oof_enter_q),
        .oof_exit_i      (oof_exit_q),
        .oof_level_i     (oof_prev_q),
        .oof_abort_i     (ctrl_q[TCE_CTRL_ABT_BIT]),
        .frame_recovery_event_mask_i     (ctrl_q[TCE_CTRL_OOFM_BIT]),
        .evt_o           (ch_evt[g]),
        .tx_run_o        (tx_run[g]),
        .tx_susp_o       (tx_susp[g]),
        .rx_run_o        (rx_run[g]),
        .rx_susp_o       (rx_susp[g]),
        .rx_ones_o       (rx_ones[g])
      );
    end
  endgenerate

  // Running receive channels flush their FIFO as the frame is lost [R13]
  logic [NUM_CH-1:0]   oof_flush;
  assign oof_flush = {NUM_CH{oof_enter_q}} & rx_run;

  // Register bus, status and interrupt
  logic [TCE_EV_W-1:0] status_q;
  logic [TCE_EV_W-1:0] status_d;
  logic [TCE_EV_W-1:0] mask_q;
  logic [TCE_EV_W-1:0] mask_d;
  logic [TCE_EV_W-1:0] evt_any;
  logic                ack_d;
  logic                req;
  logic [31:0]         rdat_d;
  logic                irq_d;
  logic                wr;
  logic                rd;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;
  assign rd  = req && !wb_we_i;

  always_comb begin
    evt_any = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      evt_any = evt_any | ch_evt[i];
    end
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    act_tx = '0;
    act_rx = '0;
    rdat_d = 32'h0000_0000;
    ack_d  = req;
    if (wr && wb_sel_i[0] && wb_adr_i == TCE_CTRL_ADDR) ctrl_d = wb_dat_i[4:0];
    if (wr && wb_adr_i == TCE_MASK_ADDR) begin
      if (wb_sel_i[0]) mask_d[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) mask_d[8]   = wb_dat_i[8];
    end
    // Activate commands: host reactivation path [R07] [R10] [R14]
    if (wr && wb_adr_i == TCE_ACT_ADDR) begin
      if (wb_sel_i[0]) act_tx = wb_dat_i[NUM_CH-1:0];
      if (wb_sel_i[1]) act_rx = wb_dat_i[TCE_ACT_RX_LSB +: NUM_CH];
    end
    if (rd) begin
      case (wb_adr_i)
        TCE_CTRL_ADDR:   rdat_d[4:0] = ctrl_q;
        TCE_ACT_ADDR: begin
          rdat_d[NUM_CH-1:0]                  = tx_run;
          rdat_d[TCE_ACT_RX_LSB +: NUM_CH]    = rx_run;
        end
        TCE_STATUS_ADDR: rdat_d[TCE_EV_W-1:0] = status_q;
        TCE_MASK_ADDR:   rdat_d[TCE_EV_W-1:0] = mask_q;
        TCE_SUSP_ADDR: begin
          rdat_d[NUM_CH-1:0]                  = tx_susp;
          rdat_d[TCE_ACT_RX_LSB +: NUM_CH]    = rx_susp;
        end
        default:         rdat_d = 32'h0000_0000;
      endcase
    end
    // Read clears status; a same-cycle event survives the clear.
    // No end-of-message bit exists in transparent mode [R02]
    status_d = status_q;
    if (rd && wb_adr_i == TCE_STATUS_ADDR) status_d = '0;
    status_d = status_d | evt_any;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q         <= TCE_CTRL_RST;
      status_q       <= TCE_STATUS_RST;
      mask_q         <= TCE_MASK_RST;
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0000_0000;
      irq_o          <= 1'b0;
      tx_idle_code_o <= '0;
      tx_bus_stop_o  <= '0;
      rx_discard_o   <= '0;
      rx_all_ones_o  <= '0;
    end else begin
      ctrl_q         <= ctrl_d;
      status_q       <= status_d;
      mask_q         <= mask_d;
      wb_ack_o       <= ack_d;
      wb_dat_o       <= rdat_d;
      irq_o          <= irq_d;
      tx_idle_code_o <= tx_susp;                              // [R06] [R16]
      tx_bus_stop_o  <= tx_susp;                              // [R05]
      rx_discard_o   <= rx_susp | oof_flush;                  // [R09] [R12] [R13]
      rx_all_ones_o  <= rx_ones;                              // [R13]
    end
  end

endmodule : tce_top

// file: tce_monitor.sv
// Checker for the tce_top ports.
// Assumes binding to tce_top, one clock domain.
`timescale 1ns/1ps
module tce_monitor
  import tce_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              out_of_frame_i,
  input wire logic [NUM_CH-1:0] tx_data_need_i,
  input wire logic [NUM_CH-1:0] tx_next_host_i,
  input wire logic [NUM_CH-1:0] tx_fifo_empty_i,
  input wire logic [NUM_CH-1:0] tx_dev_owns_i,
  input wire logic [NUM_CH-1:0] rx_fifo_ovf_i,
  input wire logic [NUM_CH-1:0] rx_dev_buf_i,
  input wire logic [NUM_CH-1:0] rx_fifo_orun_i,
  input wire logic [NUM_CH-1:0] tx_idle_code_o,
  input wire logic [NUM_CH-1:0] tx_bus_stop_o,
  input wire logic [NUM_CH-1:0] rx_discard_o,
  input wire logic [NUM_CH-1:0] rx_all_ones_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire tx_err = !tx_idle_code_o[0] && tx_data_need_i[0]
                && (tx_next_host_i[0] || (tx_fifo_empty_i[0] && tx_dev_owns_i[0]));
  wire rx_err = !rx_discard_o[0] && ((rx_fifo_ovf_i[0] && !rx_dev_buf_i[0])
                || (rx_fifo_orun_i[0] && rx_dev_buf_i[0]));
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_rx_hold; !rx_discard_o[0] [*3]; endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |-> wb_dat_o == 32'h0; endproperty
  property p_stop;
    $fell(tx_bus_stop_o[0]) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 8'h04);
  endproperty
  property p_tx_err; tx_err |-> ##[1:3] tx_idle_code_o[0]; endproperty
  property p_indep; tx_err && !rx_err && !rx_discard_o[0] |=> s_rx_hold; endproperty
  property p_rx_err; rx_err |-> ##[1:3] rx_discard_o[0]; endproperty
  property p_excl; (rx_all_ones_o & rx_discard_o) == '0; endproperty
  property p_ones; $rose(rx_all_ones_o[0]) |-> $past(out_of_frame_i, 3); endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_stop: assert property (p_stop) else $error("bus stop left without activate");
  a_tx_err: assert property (p_tx_err) else $error("tx error kept running");
  a_indep: assert property (p_indep) else $error("rx stopped by tx error");
  a_rx_err: assert property (p_rx_err) else $error("rx error kept running");
  a_excl: assert property (p_excl) else $error("ones while stopped");
  a_ones: assert property (p_ones) else $error("ones without frame loss");
endmodule : tce_monitor

bind tce_top tce_monitor #(.NUM_CH(NUM_CH)) tce_monitor_inst (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .out_of_frame_i(out_of_frame_i), .tx_data_need_i(tx_data_need_i),
  .tx_next_host_i(tx_next_host_i), .tx_fifo_empty_i(tx_fifo_empty_i),
  .tx_dev_owns_i(tx_dev_owns_i), .rx_fifo_ovf_i(rx_fifo_ovf_i), .rx_dev_buf_i(rx_dev_buf_i),
  .rx_fifo_orun_i(rx_fifo_orun_i), .tx_idle_code_o(tx_idle_code_o),
  .tx_bus_stop_o(tx_bus_stop_o), .rx_discard_o(rx_discard_o), .rx_all_ones_o(rx_all_ones_o));

// file: tce_framer_model.sv
// Framer model: free-running bit clock, frame sync and out-of-frame level.
// Assumes the bench sets frame length and requests sync glitches and frame loss.
`timescale 1ns/1ps
module tce_framer_model (
  input  wire logic [10:0] len_i,
  input  wire logic        glitch_i,
  input  wire logic        oof_req_i,
  output logic             link_clk_o,
  output logic             sync_o,
  output logic             oof_o
);
  logic [10:0] cnt_q = 11'h000;
  initial begin
    link_clk_o = 1'b0;
    sync_o = 1'b0;
    oof_o = 1'b0;
  end
  always #160 link_clk_o = ~link_clk_o;
  // Change on the falling edge so the pins are settled at the rise
  always @(negedge link_clk_o) begin
    cnt_q <= (cnt_q + 11'h001 >= len_i) ? 11'h000 : cnt_q + 11'h001;
    sync_o <= (cnt_q == 11'h000) || glitch_i;
    oof_o <= oof_req_i;
  end
endmodule : tce_framer_model

// file: tb_top.sv
// Self-checking bench for tce_top with a framer model.
// Assumes a 25 MHz system clock and a 320 ns link clock.
`timescale 1ns/1ps
module tb_top
  import tce_pkg::*;
;
  localparam logic [7:0] ST = TCE_STATUS_ADDR;
  localparam logic [7:0] AC = TCE_ACT_ADDR;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, glitch = 0, oof_req = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, junk;
  logic        ack, irq, lclk, sync, out_of_frame_error;
  logic [7:0]  t_done = 0, t_eob = 0, t_need = 0, t_host = 0, t_empty = 0, t_owns = 0;
  logic [7:0]  r_done = 0, r_eob = 0, r_ovf = 0, r_buf = 8'hFF, r_orun = 0;
  logic [7:0]  idle, stop, disc, ones;
  logic [10:0] flen = TCE_LEN_E1;
  int          n_errors = 0, checked = 0, cycles = 0;
  always #20 clk = ~clk;
  tce_top #(.NUM_CH(8)) tce_top_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .link_clk_i(lclk),
    .receive_frame_sync_i(sync), .out_of_frame_i(out_of_frame_error), .tx_buf_done_i(t_done),
    .tx_eob_en_i(t_eob), .tx_data_need_i(t_need), .tx_next_host_i(t_host),
    .tx_fifo_empty_i(t_empty), .tx_dev_owns_i(t_owns), .rx_buf_done_i(r_done),
    .rx_eob_en_i(r_eob), .rx_fifo_ovf_i(r_ovf), .rx_dev_buf_i(r_buf), .rx_fifo_orun_i(r_orun),
    .tx_idle_code_o(idle), .tx_bus_stop_o(stop), .rx_discard_o(disc), .rx_all_ones_o(ones));
  tce_framer_model tce_framer_model_inst (.len_i(flen), .glitch_i(glitch),
    .oof_req_i(oof_req), .link_clk_o(lclk), .sync_o(sync), .oof_o(out_of_frame_error));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    junk = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, junk, exp);
  endtask : rd
  task automatic strobe(input int k);
    @(posedge clk);
    case (k)
      0: t_done <= 8'h01; // Descriptors carry no end-of-message flag
      1: r_done <= 8'h01;
      2: t_need <= 8'h01;
      3: r_ovf <= 8'h01;
      default: r_orun <= 8'h01;
    endcase
    @(posedge clk);
    {t_done, r_done, t_need, r_ovf, r_orun} <= '0;
    repeat (3) @(posedge clk);
  endtask : strobe
  task automatic glitch_at(input logic [10:0] len);
    @(posedge sync);
    wb(1'b0, ST, 32'h0);
    repeat (len * 4) @(posedge clk);
    glitch <= 1'b1;
    repeat (10) @(posedge clk);
    glitch <= 1'b0;
    repeat (30) @(posedge clk);
    wb(1'b0, ST, 32'h0);
  endtask : glitch_at
  task automatic t_reset();
    chk("idle", idle, 8'hFF);
    chk("discard", disc, 8'hFF);
    rd("ctrl", TCE_CTRL_ADDR, 32'h0);
    rd("act", AC, 32'h0);
    rd("status", ST, 32'h0);
    rd("mask", TCE_MASK_ADDR, 32'h0);
    rd("susp", TCE_SUSP_ADDR, 32'hFFFF);
    rd("unmapped", 8'h14, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_events();
    wb(1'b1, TCE_MASK_ADDR, 32'h1FF);
    wb(1'b1, AC, 32'h303);
    repeat (3) @(posedge clk);
    chk("idle run", idle, 8'hFC);
    rd("act", AC, 32'h303);
    t_eob <= 8'h01;
    r_eob <= 8'h01;
    strobe(0);
    chk("irq", irq, 1'b1);
    rd("eob tx", ST, 32'h1);
    rd("cleared", ST, 32'h0);
    chk("irq off", irq, 1'b0);
    strobe(1);
    rd("eob rx", ST, 32'h2);
    {t_eob, r_eob} <= '0;
    strobe(0);
    strobe(1);
    rd("eob disabled", ST, 32'h0);
    wb(1'b1, TCE_MASK_ADDR, 32'h1FE);
    t_eob <= 8'h01;
    strobe(0);
    chk("irq masked", irq, 1'b0);
    rd("eob masked", ST, 32'h1);
    wb(1'b1, TCE_MASK_ADDR, 32'h1FF);
    $display("t_events done");
  endtask : t_events
  task automatic t_tx();
    t_host <= 8'h01;
    strobe(2);
    t_host <= 8'h00;
    chk("idle onr", idle, 8'hFD);
    chk("stop onr", stop, 8'hFD);
    chk("rx kept", disc, 8'hFC);
    rd("onr tx", ST, 32'h8);
    rd("susp", TCE_SUSP_ADDR, 32'hFCFD);
    wb(1'b1, AC, 32'h1);
    repeat (3) @(posedge clk);
    chk("idle back", idle, 8'hFC);
    {t_empty, t_owns} <= {8'h01, 8'h01};
    strobe(2);
    {t_empty, t_owns} <= '0;
    chk("idle run err", idle, 8'hFD);
    rd("run tx", ST, 32'h10);
    wb(1'b1, AC, 32'h1);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_rx();
    r_buf <= 8'hFE;
    strobe(3);
    r_buf <= 8'hFF;
    chk("disc onr", disc, 8'hFD);
    rd("onr rx", ST, 32'h20);
    wb(1'b1, AC, 32'h100);
    repeat (3) @(posedge clk);
    chk("disc back", disc, 8'hFC);
    strobe(4);
    chk("disc run err", disc, 8'hFD);
    chk("tx kept", idle, 8'hFC);
    rd("run rx", ST, 32'h40);
    wb(1'b1, AC, 32'h100);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_frame();
    logic [10:0] lens [5] = '{TCE_LEN_T1, TCE_LEN_E1, TCE_LEN_2E1, TCE_LEN_4E1, TCE_LEN_E1};
    logic [31:0] cfg [3] = '{32'h1, 32'h11, 32'h9};
    for (int m = 0; m < 5; m++) begin
      wb(1'b1, TCE_CTRL_ADDR, 32'(m));
      flen <= lens[m];
      repeat (1) @(posedge sync);
      glitch_at(lens[m]);
      chk("frame_alignment_change_error", junk, (m < 4) ? 32'h80 : 32'h0);
      chk("frame_alignment_change_error run", disc, 8'hFC);
    end
    wb(1'b1, TCE_CTRL_ADDR, 32'h9);
    glitch_at(TCE_LEN_E1);
    chk("frame_alignment_change_error abort", junk, 32'h80);
    chk("frame_alignment_change_error susp", disc, 8'hFF);
    repeat (2) @(posedge sync);
    wb(1'b1, AC, 32'h300);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, TCE_CTRL_ADDR, cfg[k]);
      wb(1'b0, ST, 32'h0);
      oof_req <= 1'b1;
      repeat (30) @(posedge clk);
      chk("ones", ones, (k == 2) ? 8'h00 : 8'h03);
      chk("oof disc", disc, (k == 2) ? 8'hFF : 8'hFC);
      oof_req <= 1'b0;
      repeat (30) @(posedge clk);
      chk("ones end", ones, 8'h00);
      wb(1'b0, ST, 32'h0);
      chk("oof status", junk & 32'h17F, (k == 0) ? 32'h104 : 32'h100);
    end
    wb(1'b1, AC, 32'h300);
    $display("t_frame done");
  endtask : t_frame
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_events();
    t_tx();
    t_rx();
    t_frame();
    conclude();
  end
endmodule : tb_top
